// file: lcdld_defines.svh
// Constants of the LCD/LED panel scan block: register indices, fields, resets, timing.
`ifndef LCDLD_DEFINES_SVH
`define LCDLD_DEFINES_SVH
// ----------------------------------------------------------------------
// Register indices (byte address is four times the index).
// ----------------------------------------------------------------------
`define LCDLD_IDX_PINSEL 16'h0092
`define LCDLD_IDX_DISPCTL 16'h00b1
`define LCDLD_IDX_DRVCTL 16'h00b2
`define LCDLD_IDX_STATUS 16'h00b3
`define LCDLD_IDX_P4SEL 16'h00ae
`define LCDLD_IDX_RAM_BASE 16'hf000
`define LCDLD_IDX_RAM_LAST 16'hf02f
// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define LCDLD_RST_PINSEL 8'h7f
`define LCDLD_RST_P4SEL 8'h80
`define LCDLD_RST_DISPCTL 8'h0c
`define LCDLD_RST_DRVCTL 8'h00
// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define LCDLD_FRM_LSB 0
`define LCDLD_DUTY_LSB 2
`define LCDLD_HBIAS_BIT 5
`define LCDLD_PUMP_BIT 6
`define LCDLD_LED_BIT 7
`define LCDLD_BRIGHT_LSB 0
`define LCDLD_CLKSEL_BIT 4
`define LCDLD_P0SEG_LSB 0
`define LCDLD_PORT2_LOW_SEGMENT_SELECT_LSB 3
`define LCDLD_PORT2_HIGH_SEGMENT_SELECT_LSB 5
`define LCDLD_PORT4_SEGMENT_SELECT_LSB 4
// ----------------------------------------------------------------------
// Timing: ticks of the display clock per common slot, one byte per rate code,
// rate code 3 in the top byte. Rows are for 3 to 8 commons.
// ----------------------------------------------------------------------
`define LCDLD_SLOT_C3 32'h6f80a1c0
`define LCDLD_SLOT_C4 32'h7080a1be
`define LCDLD_SLOT_C5 32'h50606f8e
`define LCDLD_SLOT_C6 32'h38405060
`define LCDLD_SLOT_C7 32'h38404f60
`define LCDLD_SLOT_C8 32'h3840505f
`define LCDLD_LED_DEAD_TICKS 8'h04
`define LCDLD_LED_SEG_MAX 36
`endif

// file: lcdld_pkg.sv
// Types shared by the LCD/LED panel scan block.
package lcdld_pkg;
   // Phase of a common slot; LED operation blanks commons in the dead phase.
   typedef enum logic [1:0] {
      LCDLD_PH_DEAD = 2'b00,
      LCDLD_PH_DRIVE = 2'b01
   } lcdld_phase_t;
   // One display memory byte.
   typedef logic [7:0] lcdld_byte_t;
endpackage : lcdld_pkg

// file: lcdld_ram.sv
// Display memory with one write port and two registered read ports.
`timescale 1ns/1ps
`default_nettype none
module lcdld_ram #(
   parameter int DEPTH = 48,
   parameter int AW = 6
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire lcdld_pkg::lcdld_byte_t wr_data,
   input wire logic [AW-1:0] a_addr,
   output lcdld_pkg::lcdld_byte_t a_data_q,
   input wire logic [AW-1:0] b_addr,
   output lcdld_pkg::lcdld_byte_t b_data_q
);
   import lcdld_pkg::*;
   // The address must cover the depth.
   if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad_depth
      $error("lcdld_ram depth does not fit the address width.");
   end
   // Storage array; contents are undefined until software writes them.
   lcdld_byte_t mem [DEPTH];
   // Write port.
   always_ff @(posedge clk) begin
      if (wr_en && int'(wr_addr) < DEPTH) begin
         mem[wr_addr] <= wr_data;
      end
   end
   // Bus read port, registered.
   always_ff @(posedge clk) begin
      a_data_q <= (int'(a_addr) < DEPTH) ? mem[a_addr] : 8'h00;
   end
   // Scan read port, registered.
   always_ff @(posedge clk) begin
      b_data_q <= (int'(b_addr) < DEPTH) ? mem[b_addr] : 8'h00;
   end
endmodule : lcdld_ram
`default_nettype wire

// file: lcdld_top.sv
// LCD/LED panel scan controller with APB register and display memory access.
`timescale 1ns/1ps
`default_nettype none
`include "lcdld_defines.svh"
module lcdld_top #(
   parameter int NSEG = 45,
   parameter int RAM_DEPTH = 48
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic SLOW_TICK,
   input wire logic FAST_TICK,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [17:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic PREADY,
   output logic [31:0] PRDATA,
   output logic PSLVERR,
   output logic [7:0] COM_ACT,
   output logic [7:0] COM_N,
   output logic [NSEG-1:0] SEG,
   output logic FRAME_INV,
   output logic LED_MODE,
   output logic DMX_MODE,
   output logic [7:0] DMX_ANODE,
   output logic PUMP_EN,
   output logic HALF_BIAS,
   output logic [3:0] BRIGHT,
   output logic [6:0] P0_SEG_EN,
   output logic [6:0] P2_SEG_EN,
   output logic [7:0] P4_SEG_EN
);
   import lcdld_pkg::*;
   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (NSEG < `LCDLD_LED_SEG_MAX + 1 || NSEG > RAM_DEPTH || RAM_DEPTH > 64) begin : g_bad
      $error("lcdld_top segment count or memory depth out of range.");
   end
   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   logic [7:0] pinsel_q; // Port 0 and port 2 segment selects.
   logic [7:0] p4sel_q; // Port 4 segment select and touch reference field.
   logic [7:0] dispctl_q; // Rate, duty, bias, pump and LED mode.
   logic [7:0] drvctl_q; // Brightness and clock source.
   logic [15:0] idx; // Word index of the bus address.
   logic ram_hit; // Access falls in display memory.
   logic reg_hit; // Access hits a control register.
   logic ram_wait_q; // First access cycle of a memory read is spent.
   logic wr_go; // A write completes in this cycle.
   logic [5:0] ram_off; // Offset into display memory.
   lcdld_byte_t ram_rdata; // Bus read data from the memory.
   // Address decode from the word index.
   assign idx = PADDR[17:2];
   assign ram_hit = idx >= `LCDLD_IDX_RAM_BASE && idx <= `LCDLD_IDX_RAM_LAST;
   assign reg_hit = idx == `LCDLD_IDX_PINSEL || idx == `LCDLD_IDX_P4SEL
                    || idx == `LCDLD_IDX_DISPCTL || idx == `LCDLD_IDX_DRVCTL
                    || idx == `LCDLD_IDX_STATUS;
   assign ram_off = idx[5:0];
   // Memory reads wait one cycle for the registered read port.
   assign PREADY = !(PSEL && PENABLE && !PWRITE && ram_hit && !ram_wait_q);
   assign PSLVERR = PSEL && PENABLE && PREADY && !ram_hit && !reg_hit;
   assign wr_go = PSEL && PENABLE && PREADY && PWRITE && PSTRB[0];
   // Wait-state flag for memory reads.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ram_wait_q <= 1'b0;
      end else begin
         ram_wait_q <= PSEL && PENABLE && !PWRITE && ram_hit && !ram_wait_q;
      end
   end
   // Control register writes; the status word is read only.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pinsel_q <= `LCDLD_RST_PINSEL;
         p4sel_q <= `LCDLD_RST_P4SEL;
         dispctl_q <= `LCDLD_RST_DISPCTL;
         drvctl_q <= `LCDLD_RST_DRVCTL;
      end else if (wr_go) begin
         // The top bit of the pin select has no storage.
         if (idx == `LCDLD_IDX_PINSEL) begin
            pinsel_q <= {1'b0, PWDATA[6:0]};
         end
         if (idx == `LCDLD_IDX_P4SEL) begin
            p4sel_q <= PWDATA[7:0];
         end
         if (idx == `LCDLD_IDX_DISPCTL) begin
            dispctl_q <= PWDATA[7:0];
         end
         if (idx == `LCDLD_IDX_DRVCTL) begin
            drvctl_q <= {3'h0, PWDATA[4:0]};
         end
      end
   end
   // ----------------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------------
   logic [1:0] frm; // Frame rate code.
   logic [3:0] ncom; // Number of commons scanned.
   logic led_mode; // LED operation.
   logic dmx_mode; // Dot matrix operation.
   logic tick_en; // One display clock tick.
   assign frm = dispctl_q[`LCDLD_FRM_LSB +: 2];
   // Duty codes below two fall back to three commons.
   // common count
   assign ncom = (dispctl_q[`LCDLD_DUTY_LSB +: 3] < 3'h2) ? 4'h3
                 : {1'b0, dispctl_q[`LCDLD_DUTY_LSB +: 3]} + 4'h1;
   assign led_mode = dispctl_q[`LCDLD_LED_BIT];
   assign dmx_mode = led_mode && dispctl_q[`LCDLD_PUMP_BIT];
   assign tick_en = drvctl_q[`LCDLD_CLKSEL_BIT] ? FAST_TICK : SLOW_TICK;
   // ----------------------------------------------------------------------
   // Slot length lookup
   // ----------------------------------------------------------------------
   logic [31:0] slot_row; // Four slot lengths for the current duty.
   logic [7:0] slot_lcd; // Slot length in LCD operation.
   logic [7:0] slot_len; // Slot length in force.
   // Row pick by common count.
   always_comb begin
      case (ncom)
         4'h3: slot_row = `LCDLD_SLOT_C3;
         4'h4: slot_row = `LCDLD_SLOT_C4;
         4'h5: slot_row = `LCDLD_SLOT_C5;
         4'h6: slot_row = `LCDLD_SLOT_C6;
         4'h7: slot_row = `LCDLD_SLOT_C7;
         default: slot_row = `LCDLD_SLOT_C8;
      endcase
   end
   assign slot_lcd = slot_row[8*frm +: 8];
   assign slot_len = led_mode ? {1'b0, slot_lcd[7:1]} : slot_lcd;
   // ----------------------------------------------------------------------
   // Slot and common sequencing
   // ----------------------------------------------------------------------
   logic [7:0] tick_cnt_q; // Ticks spent in the current slot.
   logic [2:0] com_q; // Active common.
   logic [2:0] next_com; // Common of the following slot.
   logic slot_end; // Last tick of a slot.
   logic frame_inv_q; // Toggles at each frame end.
   lcdld_phase_t phase_q; // Dead or drive phase.
   assign slot_end = tick_en && (tick_cnt_q >= slot_len - 8'h01);
   assign next_com = ({1'b0, com_q} + 4'h1 >= ncom) ? 3'h0 : com_q + 3'h1;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tick_cnt_q <= 8'h00;
      end else if (slot_end) begin
         tick_cnt_q <= 8'h00;
      end else if (tick_en) begin
         tick_cnt_q <= tick_cnt_q + 8'h01;
      end
   end
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         com_q <= 3'h0;
         frame_inv_q <= 1'b0;
      end else if (slot_end) begin
         com_q <= next_com;
         if (next_com == 3'h0) begin
            frame_inv_q <= !frame_inv_q;
         end
      end
   end
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         phase_q <= LCDLD_PH_DEAD;
      end else begin
         case (phase_q)
            LCDLD_PH_DEAD: begin
               if (slot_end) begin
                  phase_q <= LCDLD_PH_DEAD;
               end else if (tick_en && tick_cnt_q + 8'h01 >= `LCDLD_LED_DEAD_TICKS) begin
                  phase_q <= LCDLD_PH_DRIVE;
               end
            end
            LCDLD_PH_DRIVE: begin
               if (slot_end) begin
                  phase_q <= LCDLD_PH_DEAD;
               end
            end
            default: phase_q <= LCDLD_PH_DEAD;
         endcase
      end
   end
   // ----------------------------------------------------------------------
   // Display memory and scan sweep
   // ----------------------------------------------------------------------
   logic [5:0] scan_idx_q; // Byte being fetched.
   logic [5:0] scan_got_q; // Byte whose data arrives now.
   lcdld_byte_t scan_data; // Scan read data.
   logic [RAM_DEPTH-1:0] shadow_q; // Bits of the next common.
   lcdld_byte_t dmx_shadow_q; // Row byte of the next common.
   logic [NSEG-1:0] seg_q; // Segment levels of the current slot.
   lcdld_byte_t dmx_row_q; // Row byte of the current slot.
   logic bit_ok; // Fetched bit exists for this segment.
   lcdld_ram #(.DEPTH(RAM_DEPTH), .AW(6)) u_ram (
      .clk(CLK),
      .wr_en(wr_go && ram_hit),
      .wr_addr(ram_off),
      .wr_data(PWDATA[7:0]),
      .a_addr(ram_off),
      .a_data_q(ram_rdata),
      .b_addr(scan_idx_q),
      .b_data_q(scan_data)
   );
   // Low segments hold fewer common bits.
   // narrow low bytes
   assign bit_ok = scan_got_q >= 6'h08 || next_com < 3'h3 || {3'h0, next_com} < scan_got_q;
   // Continuous sweep over all bytes, one per clock.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         scan_idx_q <= 6'h00;
         scan_got_q <= 6'h00;
      end else begin
         scan_idx_q <= (int'(scan_idx_q) >= RAM_DEPTH - 1) ? 6'h00 : scan_idx_q + 6'h01;
         scan_got_q <= scan_idx_q;
      end
   end
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         shadow_q <= '0;
         dmx_shadow_q <= 8'h00;
      end else begin
         shadow_q[scan_got_q] <= scan_data[next_com] && bit_ok;
         if (scan_got_q == {3'h0, next_com}) begin
            dmx_shadow_q <= scan_data;
         end
      end
   end
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         seg_q <= '0;
         dmx_row_q <= 8'h00;
      end else begin
         for (int i = 0; i < NSEG; i++) begin
            seg_q[i] <= (slot_end ? shadow_q[i] : seg_q[i])
                        && !(led_mode && i >= `LCDLD_LED_SEG_MAX) && !dmx_mode;
         end
         dmx_row_q <= slot_end ? dmx_shadow_q : dmx_row_q;
      end
   end
   // ----------------------------------------------------------------------
   // Panel outputs
   // ----------------------------------------------------------------------
   logic drive; // LED drive phase.
   assign drive = phase_q == LCDLD_PH_DRIVE;
   assign SEG = seg_q;
   assign COM_ACT = led_mode ? 8'h00 : (8'h01 << com_q);
   assign COM_N = (led_mode && drive) ? ~(8'h01 << com_q) : 8'hff;
   assign DMX_ANODE = (dmx_mode && drive) ? (dmx_row_q & ~(8'h01 << com_q)) : 8'h00;
   assign FRAME_INV = frame_inv_q;
   assign LED_MODE = led_mode;
   assign DMX_MODE = dmx_mode;
   assign PUMP_EN = dispctl_q[`LCDLD_PUMP_BIT];
   assign HALF_BIAS = dispctl_q[`LCDLD_HBIAS_BIT];
   assign BRIGHT = drvctl_q[`LCDLD_BRIGHT_LSB +: 4];
   // ----------------------------------------------------------------------
   // Pin role decode
   // ----------------------------------------------------------------------
   logic [1:0] p2h_code; // Port 2 high group code.
   logic [1:0] p2l_code; // Port 2 low group code.
   logic [2:0] p0_code; // Port 0 code.
   logic [3:0] p4_code; // Port 4 code.
   assign p2h_code = pinsel_q[`LCDLD_PORT2_HIGH_SEGMENT_SELECT_LSB +: 2];
   assign p2l_code = pinsel_q[`LCDLD_PORT2_LOW_SEGMENT_SELECT_LSB +: 2];
   assign p0_code = pinsel_q[`LCDLD_P0SEG_LSB +: 3];
   assign p4_code = p4sel_q[`LCDLD_PORT4_SEGMENT_SELECT_LSB +: 4];
   assign P0_SEG_EN = ~(7'h7f >> p0_code);
   assign P2_SEG_EN[6:4] = ~(3'h7 >> p2h_code);
   assign P2_SEG_EN[3:1] = ~(3'h7 >> p2l_code);
   assign P2_SEG_EN[0] = 1'b0;
   assign P4_SEG_EN = (p4_code >= 4'h8) ? 8'hff : ~(8'hff >> p4_code);
   // ----------------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------------
   always_comb begin
      PRDATA = 32'h0000_0000;
      if (ram_hit) begin
         PRDATA = {24'h000000, ram_rdata};
      end else if (idx == `LCDLD_IDX_PINSEL) begin
         PRDATA = {24'h000000, pinsel_q};
      end else if (idx == `LCDLD_IDX_P4SEL) begin
         PRDATA = {24'h000000, p4sel_q};
      end else if (idx == `LCDLD_IDX_DISPCTL) begin
         PRDATA = {24'h000000, dispctl_q};
      end else if (idx == `LCDLD_IDX_DRVCTL) begin
         PRDATA = {24'h000000, drvctl_q};
      end else if (idx == `LCDLD_IDX_STATUS) begin
         PRDATA = {27'h0000000, drive, frame_inv_q, com_q};
      end
   end
   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   sequence s_ctl_write;
      PSEL && PENABLE && PWRITE && PSTRB[0] && idx == `LCDLD_IDX_DISPCTL;
   endsequence
   sequence s_slot_turn;
      slot_end && led_mode;
   endsequence
   rate_field_a: assert property (s_ctl_write ##1 1'b1 |-> frm == $past(PWDATA[1:0]))
      else $error("Rate field not taken from write.");
   com_range_a: assert property ({1'b0, com_q} < ncom || $changed(ncom) || $past(slot_end) == 1'b0)
      else $error("Active common beyond duty.");
   lcd_onehot_a: assert property (!led_mode |-> $onehot(COM_ACT) && COM_N == 8'hff)
      else $error("LCD commons not one-hot.");
   led_dead_a: assert property (s_slot_turn |=> COM_N == 8'hff)
      else $error("LED common driven without dead time.");
   led_slot_a: assert property (led_mode |-> slot_len == {1'b0, slot_lcd[7:1]})
      else $error("LED slot not half the LCD slot.");
   tick_hold_a: assert property (!tick_en |=> $stable(tick_cnt_q))
      else $error("Scan advanced without a tick.");
   led_seg_cut_a: assert property (led_mode |=> SEG[NSEG-1:`LCDLD_LED_SEG_MAX] == '0)
      else $error("LED segment above limit driven.");
   dmx_diag_a: assert property (DMX_ANODE[com_q] == 1'b0)
      else $error("Dot matrix unused bit driven.");
   p0_count_a: assert property ($countones(P0_SEG_EN) == int'(p0_code))
      else $error("Port 0 segment count wrong.");
   p4_all_a: assert property (p4_code == 4'h8 |-> P4_SEG_EN == 8'hff)
      else $error("Port 4 full code not all segments.");
   p2_low_a: assert property ($countones(P2_SEG_EN[3:1]) == int'(p2l_code))
      else $error("Port 2 low group count wrong.");
   p2_high_a: assert property ($countones(P2_SEG_EN[6:4]) == int'(p2h_code))
      else $error("Port 2 high group count wrong.");
endmodule : lcdld_top
`default_nettype wire

// file: lcdld_panel.sv
// Panel model: records the segment levels seen while each common is active.
`timescale 1ns/1ps
`default_nettype none
module lcdld_panel (
   input wire logic clk,
   input wire logic [7:0] com_act,
   input wire logic [44:0] seg,
   output logic [9:0] cap [8]
);
   // -----------------------------------------------------------------
   // Capture
   // -----------------------------------------------------------------
   // scan capture: the glass sees segments 0 to 9 against the live common.
   always_ff @(posedge clk) begin
      for (int k = 0; k < 8; k++) begin
         if (com_act[k]) begin
            cap[k] <= seg[9:0];
         end
      end
   end
endmodule : lcdld_panel
`default_nettype wire

// file: tb.sv
// Self-checking bench of the LCD/LED scan block.
`timescale 1ns/1ps
`default_nettype none
`include "lcdld_defines.svh"
module tb;
   logic clk = 1'b0, arst_n = 1'b0, slow = 1'b0, fast = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pw = 1'b0;
   logic [17:0] pa = 18'h00000;
   logic [31:0] pwd = 32'h00000000;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, finv, ledm, dmxm, pump;
   logic [31:0] prdata;
   logic [7:0] com_act, com_n, p4en, anode;
   logic [44:0] seg;
   logic [3:0] bright;
   logic [6:0] p0en, p2en;
   logic [9:0] cap [8];
   logic [5:0] tk = 6'h00;
   int miscompares = 0, checks = 0, cyc = 0;
   // -----------------------------------------------------------------
   // Clock, display ticks and watchdog
   // -----------------------------------------------------------------
   initial begin
      forever #2.5 clk = ~clk;
   end
   // Ticks are 50 cycles apart so every slot sees a full memory sweep.
   always @(posedge clk) begin
      tk <= (tk == 6'd49) ? 6'h00 : tk + 6'h01;
      fast <= (tk == 6'd0);
      slow <= (tk == 6'd25);
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         miscompares++;
         close_out();
      end
   end
   lcdld_top uut (.CLK(clk), .ARST_N(arst_n), .SLOW_TICK(slow), .FAST_TICK(fast),
      .PSEL(psel), .PENABLE(pen), .PWRITE(pw), .PADDR(pa), .PWDATA(pwd), .PSTRB(pstrb),
      .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .COM_ACT(com_act), .COM_N(com_n),
      .SEG(seg), .FRAME_INV(finv), .LED_MODE(ledm), .DMX_MODE(dmxm), .DMX_ANODE(anode),
      .PUMP_EN(pump), .HALF_BIAS(), .BRIGHT(bright), .P0_SEG_EN(p0en), .P2_SEG_EN(p2en),
      .P4_SEG_EN(p4en));
   lcdld_panel panel (.clk(clk), .com_act(com_act), .seg(seg), .cap(cap));
   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd,
      output logic [7:0] rd, output logic err);
      psel <= 1'b1;
      pw <= w;
      pa <= {idx, 2'b00};
      pwd <= {24'h000000, wd};
      @(posedge clk);
      pen <= 1'b1;
      // Ready, read data and error are all taken at the same rising edge.
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
   endtask : wr
   // Returns the cycles spent until the frame flag turns.
   task automatic wait_inv(output int n);
      logic f;
      f = finv;
      n = 0;
      while (finv === f && n < 30000) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_inv
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] r;
      logic e;
      apb(1'b0, `LCDLD_IDX_PINSEL, 8'h00, r, e);
      chk(r, 8'h7f);
      apb(1'b0, `LCDLD_IDX_P4SEL, 8'h00, r, e);
      chk(r, 8'h80);
      apb(1'b0, `LCDLD_IDX_DISPCTL, 8'h00, r, e);
      chk(r, 8'h0c);
      apb(1'b0, 16'h0010, 8'h00, r, e);
      chk({e, r[6:0]}, 8'h80);
   endtask : t_reset
   // Every port 0 and port 2 code, and port 4 codes 0 to 8, boundaries included.
   task automatic t_pins();
      logic [2:0] m;
      for (int c = 0; c < 8; c++) begin
         m = 3'b111 << (3 - (c & 3));
         wr(`LCDLD_IDX_PINSEL, {1'b0, 2'(c), 2'(c), 3'(c)});
         chk({1'b0, p0en}, {1'b0, ~(7'h7f >> c)});
         chk({1'b0, p2en}, {1'b0, m, m, 1'b0});
      end
      for (int c = 0; c < 9; c++) begin
         wr(`LCDLD_IDX_P4SEL, {4'(c), 4'h0});
         chk(p4en, ~(8'hff >> c));
      end
   endtask : t_pins
   // Four commons on the fast tick; segment 0 masks bit 3.
   task automatic t_scan();
      logic [7:0] r;
      logic e;
      int n;
      // brightness at 15 before any pump start.
      wr(`LCDLD_IDX_DRVCTL, 8'h1f);
      chk({4'h0, bright}, 8'h0f);
      wr(`LCDLD_IDX_DISPCTL, 8'h0f);
      wr(16'hf000, 8'hff);
      wr(16'hf004, 8'h0f);
      wr(16'hf009, 8'ha5);
      apb(1'b0, 16'hf009, 8'h00, r, e);
      chk(r, 8'ha5);
      // Let one full memory sweep pass so the next slot sees the new bytes.
      repeat (64) @(posedge clk);
      wait_inv(n);
      wait_inv(n);
      chk(8'(n / 200), 8'(`LCDLD_SLOT_C4 >> 24));
      for (int k = 0; k < 4; k++) begin
         chk({7'h00, cap[k][0]}, {7'h00, k < 3});
         chk({7'h00, cap[k][4]}, 8'h01);
         chk({7'h00, cap[k][9]}, {7'h00, 1'(8'ha5 >> k)});
      end
   endtask : t_scan
   // LED operation and dot matrix.
   task automatic t_led();
      int n;
      wr(`LCDLD_IDX_DISPCTL, 8'h8f);
      n = 0;
      while (com_n === 8'hff && n < 20000) begin
         @(posedge clk);
         n++;
      end
      chk(8'($countones(~com_n)), 8'h01);
      chk({6'h00, ledm, |com_act}, 8'h02);
      chk({7'h00, |seg[44:36]}, 8'h00);
      // A whole LED frame is half the LCD frame of the same setting.
      wait_inv(n);
      wait_inv(n);
      chk(8'(n / 100), 8'(`LCDLD_SLOT_C4 >> 24));
      wr(`LCDLD_IDX_DISPCTL, 8'hcf);
      chk({6'h00, pump, dmxm}, 8'h03);
      n = 0;
      while (com_n !== 8'hfe && n < 20000) begin
         @(posedge clk);
         n++;
      end
      chk(anode, 8'hfe);
      chk({7'h00, |seg}, 8'h00);
   endtask : t_led
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_pins();
      t_scan();
      t_led();
      close_out();
   end
endmodule : tb
`default_nettype wire
